// >>> pkg/srd_defines.svh
// Summary of operation
// - Frame bit 23 must be the inverse of bit 22; this checks frame alignment.
// - Frame device-address bits are compared with the two hardware address pins.
// - Five register-select bits 20..16 choose the target register of a write.
// - Four readback modes are chosen by the mode field of readback select.
// - Writing register 0x13 sets a pointer; the next frame returns that register.
// - A new select write in the second frame is returned in the next frame.
// - Readback frames start with the marker 0b10 in the two top bits, except the echo frames of echo mode.
// - Readback frame carries fault bit 21, address 20..16, data 15..0.
// - Autostatus mode returns the status word in every transaction.
// - Status word holds fault, diagnostics, watchdog, busy, channel and ADC result.
// - Shared-select flag is set by a valid write, cleared at select fall.
// - Shared-select mode drives data-out only in a frame that begins with that flag set.
// - Echo mode returns the previous command word in every second frame.
// - CRC on accepts only 32-bit frames; CRC off accepts 24 or 32.
// - An access to a reserved register address is flagged as invalid.
`ifndef SRD_DEFINES_SVH
`define SRD_DEFINES_SVH

// ==========================================================
// Register addresses
`define SRD_NOP_ADDR       5'h00
`define SRD_RB_SELECT_ADDR 5'h13
`define SRD_RSV_LO_ADDR    5'h19
`define SRD_RSV_HI_ADDR    5'h1B
`define SRD_LAST_ADDR      5'h1C

// ==========================================================
// Field positions and values
`define SRD_PTR_MSB        4
`define SRD_PTR_LSB        0
`define SRD_MODE_MSB       9
`define SRD_MODE_LSB       8
`define SRD_SYNC_MARK      2'h2
`define SRD_RB_RESET       16'h0000
`define SRD_CRC_FILL       8'h00

// ==========================================================
// Frame lengths in serial clocks
`define SRD_LEN_CRC        6'h20
`define SRD_LEN_NOCRC      6'h18
`define SRD_CNT_MAX        6'h3F

// Reset levels of the pin synchronisers: select idles high.
`define SRD_PIN_RST        6'h02

`endif

// >>> pkg/srd_pkg.sv
`default_nettype none

package srd_pkg;

  typedef enum logic [1:0] {
    SRD_TWO_STAGE,
    SRD_AUTOSTATUS,
    SRD_SHARED,
    SRD_ECHO
  } srd_mode_t;

  typedef enum logic {
    SRD_IDLE,
    SRD_ACTIVE
  } srd_frame_t;

endpackage

`default_nettype wire

// >>> rtl/srd_sync.sv
`timescale 1ns/1ps
`default_nettype none

module srd_sync #(
  parameter logic RST_VAL = 1'b0
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Asynchronous level in, synchronised level out
  input  wire logic d,
  output logic      q
);

  logic meta_reg;
  logic sync_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_reg <= RST_VAL;
      sync_reg <= RST_VAL;
    end else begin
      meta_reg <= d;
      sync_reg <= meta_reg;
    end
  end

  assign q = sync_reg;

endmodule // srd_sync

`default_nettype wire

// >>> rtl/srd_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "srd_defines.svh"

module srd_top import srd_pkg::*; (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Serial pins
  input  wire logic        sclk,
  input  wire logic        sync_n,
  input  wire logic        sdi,
  output logic             sdo,
  output logic             sdo_oe_n,
  // Hardware address pins and fault pin
  input  wire logic        dev_addr_hi,
  input  wire logic        dev_addr_lo,
  input  wire logic        fault_pin,
  // Frame CRC enable
  input  wire logic        crc_en,
  // Status sources
  input  wire logic        digital_diag_summary,
  input  wire logic        analog_diag_summary,
  input  wire logic        watchdog_flag,
  input  wire logic        adc_busy,
  input  wire logic [4:0]  conv_channel_code,
  input  wire logic [11:0] adc_result,
  // Register file side
  input  wire logic [15:0] rb_data,
  output logic [4:0]       rb_ptr,
  output logic [1:0]       rb_mode,
  output logic             wr_strobe,
  output logic [4:0]       wr_addr,
  output logic [15:0]      wr_data,
  output logic             invalid_access
);

  // ==========================================================
  // Pin synchronisers
  localparam logic [5:0] PIN_RST = `SRD_PIN_RST;

  logic [5:0] pin_raw;
  logic [5:0] pin_s;

  assign pin_raw = {fault_pin, dev_addr_lo, dev_addr_hi, sdi, sync_n, sclk};

  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++) begin : g_sync
      srd_sync #(
        .RST_VAL (PIN_RST[gi])
      ) u_sync (
        .clk (clk),
        .rst (rst),
        .d   (pin_raw[gi]),
        .q   (pin_s[gi])
      );
    end
  endgenerate

  logic sclk_s;
  logic sync_s;
  logic sdi_s;
  logic [1:0] addr_s;
  logic fault_s;

  assign sclk_s  = pin_s[0];
  assign sync_s  = pin_s[1];
  assign sdi_s   = pin_s[2];
  assign addr_s  = {pin_s[3], pin_s[4]};
  assign fault_s = pin_s[5];

  function automatic logic is_reserved(input logic [4:0] a);
    is_reserved = ((a >= `SRD_RSV_LO_ADDR) && (a <= `SRD_RSV_HI_ADDR)) || (a > `SRD_LAST_ADDR);
  endfunction

  // ==========================================================
  // Edge detection
  logic sclk_q;
  logic sync_q;
  logic sclk_fall;
  logic sync_fall;
  logic sync_rise;

  always_ff @(posedge clk) begin
    if (rst) begin
      sclk_q <= 1'b0;
      sync_q <= 1'b1;
    end else begin
      sclk_q <= sclk_s;
      sync_q <= sync_s;
    end
  end

  assign sclk_fall = sclk_q & ~sclk_s;
  assign sync_fall = sync_q & ~sync_s;
  assign sync_rise = ~sync_q & sync_s;

  // ==========================================================
  // Frame state and receive shifter
  srd_frame_t  frame_reg;
  logic [5:0]  cnt_reg;
  logic [31:0] rx_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      frame_reg <= SRD_IDLE;
    end else begin
      case (frame_reg)
        SRD_IDLE:   if (sync_fall) frame_reg <= SRD_ACTIVE;
        SRD_ACTIVE: if (sync_rise) frame_reg <= SRD_IDLE;
        default:    frame_reg <= SRD_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_reg <= 6'h00;
      rx_reg  <= 32'h0000_0000;
    end else if (sync_fall) begin
      cnt_reg <= 6'h00;
    end else if (frame_reg == SRD_ACTIVE && sclk_fall) begin
      rx_reg <= {rx_reg[30:0], sdi_s};
      if (cnt_reg != `SRD_CNT_MAX) cnt_reg <= cnt_reg + 6'h01;
    end
  end

  // ==========================================================
  // Frame decode at the end of a frame
  logic        frame_end;
  logic        len_ok;
  logic [23:0] cmd;
  logic        slip_ok;
  logic        addr_ok;
  logic        frame_ok;
  logic [4:0]  cmd_reg_sel;
  logic [15:0] cmd_data;
  logic        cmd_rsv;

  assign frame_end = (frame_reg == SRD_ACTIVE) && sync_rise;
  // With CRC off a 32-bit frame ignores its final byte.
  assign len_ok = (cnt_reg == `SRD_LEN_CRC) || (!crc_en && cnt_reg == `SRD_LEN_NOCRC);
  assign cmd = (cnt_reg == `SRD_LEN_NOCRC) ? rx_reg[23:0] : rx_reg[31:8];
  assign slip_ok = cmd[23] == ~cmd[22];
  assign addr_ok = cmd[22:21] == addr_s;
  assign frame_ok = len_ok && slip_ok && addr_ok;
  assign cmd_reg_sel = cmd[20:16];
  assign cmd_data = cmd[15:0];
  assign cmd_rsv = is_reserved(cmd_reg_sel) ||
                   (cmd_reg_sel == `SRD_RB_SELECT_ADDR && is_reserved(cmd_data[`SRD_PTR_MSB:`SRD_PTR_LSB]));

  // ==========================================================
  // Write strobe, readback select register and invalid flag
  logic        wr_strobe_reg;
  logic [4:0]  wr_addr_reg;
  logic [15:0] wr_data_reg;
  logic        invalid_reg;
  logic [15:0] rb_reg;
  logic [23:0] last_cmd_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_strobe_reg <= 1'b0;
      invalid_reg   <= 1'b0;
      wr_addr_reg   <= 5'h00;
      wr_data_reg   <= 16'h0000;
    end else begin
      wr_strobe_reg <= frame_end && frame_ok && !cmd_rsv;
      invalid_reg   <= frame_end && frame_ok && cmd_rsv;
      if (frame_end && frame_ok) begin
        wr_addr_reg <= cmd_reg_sel;
        wr_data_reg <= cmd_data;
      end
    end
  end

  // The pointer takes effect on the very next frame, so reads can be pipelined.
  always_ff @(posedge clk) begin
    if (rst) begin
      rb_reg <= `SRD_RB_RESET;
    end else if (frame_end && frame_ok && !cmd_rsv && cmd_reg_sel == `SRD_RB_SELECT_ADDR) begin
      rb_reg <= cmd_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      last_cmd_reg <= 24'h00_0000;
    end else if (frame_end && len_ok) begin
      last_cmd_reg <= cmd;
    end
  end

  srd_mode_t mode;
  logic [4:0] ptr;

  assign mode = srd_mode_t'(rb_reg[`SRD_MODE_MSB:`SRD_MODE_LSB]);
  assign ptr  = rb_reg[`SRD_PTR_MSB:`SRD_PTR_LSB];

  // ==========================================================
  // Shared-select flag and echo phase
  logic shared_flag_reg;
  logic echo_phase_reg;

  // A valid write wins over a clear; both cannot meet in one cycle anyway.
  always_ff @(posedge clk) begin
    if (rst) begin
      shared_flag_reg <= 1'b0;
    end else if (frame_end && frame_ok) begin
      shared_flag_reg <= 1'b1;
    end else if (sync_fall) begin
      shared_flag_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || mode != SRD_ECHO) begin
      echo_phase_reg <= 1'b0;
    end else if (sync_fall) begin
      echo_phase_reg <= ~echo_phase_reg;
    end
  end

  // ==========================================================
  // Transmit frame selection
  logic [23:0] status_word;
  logic [15:0] rd_value;
  logic [23:0] payload;

  assign status_word = {`SRD_SYNC_MARK, fault_s, digital_diag_summary, analog_diag_summary,
                        watchdog_flag, adc_busy, conv_channel_code, adc_result};

  always_comb begin
    rd_value = rb_data;
    if (ptr == `SRD_RB_SELECT_ADDR) rd_value = rb_reg;
    else if (ptr == `SRD_NOP_ADDR) rd_value = 16'h0000;
    case (mode)
      SRD_TWO_STAGE:  payload = {`SRD_SYNC_MARK, fault_s, ptr, rd_value};
      SRD_AUTOSTATUS: payload = status_word;
      SRD_SHARED:     payload = status_word;
      SRD_ECHO:       payload = echo_phase_reg ? last_cmd_reg : status_word;
      default:        payload = status_word;
    endcase
  end

  // ==========================================================
  // Transmit shifter and output enable
  logic [31:0] tx_reg;
  logic        sdo_oe_n_reg;

  // The CRC byte is not generated here; trailing bits shift out as zero.
  always_ff @(posedge clk) begin
    if (rst) begin
      tx_reg <= 32'h0000_0000;
    end else if (sync_fall) begin
      tx_reg <= {payload, `SRD_CRC_FILL};
    end else if (frame_reg == SRD_ACTIVE && sclk_fall) begin
      tx_reg <= {tx_reg[30:0], 1'b0};
    end
  end

  always_ff @(posedge clk) begin
    if (rst || sync_rise) begin
      sdo_oe_n_reg <= 1'b1;
    end else if (sync_fall) begin
      sdo_oe_n_reg <= (mode == SRD_SHARED) && !shared_flag_reg;
    end
  end

  assign sdo            = tx_reg[31];
  assign sdo_oe_n       = sdo_oe_n_reg;
  assign rb_ptr         = rb_reg[`SRD_PTR_MSB:`SRD_PTR_LSB];
  assign rb_mode        = rb_reg[`SRD_MODE_MSB:`SRD_MODE_LSB];
  assign wr_strobe      = wr_strobe_reg;
  assign wr_addr        = wr_addr_reg;
  assign wr_data        = wr_data_reg;
  assign invalid_access = invalid_reg;

  // ==========================================================
  // Assertions
  AST_SLIP_BAD: assert property (@(posedge clk) disable iff (rst)
    frame_end && !slip_ok |=> !wr_strobe_reg && !invalid_reg)
    else $error("bad slip bit frame was accepted");

  AST_ADDR_MATCH: assert property (@(posedge clk) disable iff (rst)
    wr_strobe_reg |-> $past(addr_ok) && $past(frame_end))
    else $error("write strobe without address match");

  AST_REG_SEL: assert property (@(posedge clk) disable iff (rst)
    wr_strobe_reg |-> wr_addr_reg == $past(cmd_reg_sel) && wr_data_reg == $past(cmd_data))
    else $error("write address or data not from frame");

  AST_RB_SELECT: assert property (@(posedge clk) disable iff (rst)
    frame_end && frame_ok && !cmd_rsv && cmd_reg_sel == `SRD_RB_SELECT_ADDR |=> rb_reg == $past(cmd_data))
    else $error("readback select not updated");

  AST_MARKER: assert property (@(posedge clk) disable iff (rst)
    sync_fall && !(mode == SRD_ECHO && echo_phase_reg) |=> tx_reg[31:30] == `SRD_SYNC_MARK)
    else $error("sync marker missing");

  AST_SHARED_CLR: assert property (@(posedge clk) disable iff (rst)
    sync_fall |=> !shared_flag_reg)
    else $error("shared flag not cleared at select fall");

  AST_SHARED_OE: assert property (@(posedge clk) disable iff (rst)
    $fell(sdo_oe_n_reg) |-> $past(sync_fall) && ($past(mode) != SRD_SHARED || $past(shared_flag_reg)))
    else $error("data-out driven without valid write");

  AST_LEN: assert property (@(posedge clk) disable iff (rst)
    frame_end && !len_ok |=> !wr_strobe_reg && $stable(rb_reg))
    else $error("frame of wrong length accepted");

  AST_RESERVED: assert property (@(posedge clk) disable iff (rst)
    frame_end && frame_ok && cmd_rsv |=> invalid_reg && !wr_strobe_reg)
    else $error("reserved access not flagged");

  AST_ECHO: assert property (@(posedge clk) disable iff (rst)
    sync_fall && mode == SRD_ECHO && echo_phase_reg |=> tx_reg[31:8] == $past(last_cmd_reg))
    else $error("echo frame does not repeat last command");

  AST_AUTOSTATUS: assert property (@(posedge clk) disable iff (rst)
    sync_fall && mode == SRD_AUTOSTATUS |=> tx_reg[31:8] == $past(status_word))
    else $error("autostatus frame is not the status word");

endmodule // srd_top

`default_nettype wire

// >>> verification/srd_host_model.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Serial host: one sclk period is 8 clk, sclk rests low between frames.
module srd_host_model (
  // Clock
  input  wire logic clk,
  // Serial pins
  input  wire logic sdo,
  input  wire logic sdo_oe_n,
  output logic      sclk,
  output logic      sync_n,
  output logic      sdi
);
  logic [31:0] rx;
  logic        drv;

  initial begin
    sclk = 1'b0;
    sync_n = 1'b1;
    sdi = 1'b0;
    rx = '0;
    drv = 1'b0;
  end

  // Sampling just before the falling edge; a released line reads as the inverse of the last bit.
  task automatic xfer(input int len, input logic [31:0] w);
    rx = '0;
    drv = 1'b0;
    @(posedge clk) sync_n <= 1'b0;
    repeat (8) @(posedge clk);
    for (int i = len - 1; i >= 0; i--) begin
      sclk <= 1'b1;
      sdi <= w[i];
      repeat (4) @(posedge clk);
      rx = {rx[30:0], sdo_oe_n ? ~rx[0] : sdo};
      drv = drv | ~sdo_oe_n;
      sclk <= 1'b0;
      repeat (4) @(posedge clk);
    end
    sync_n <= 1'b1;
    sdi <= ~sdi;
    repeat (24) @(posedge clk);
  endtask
endmodule // srd_host_model

`default_nettype wire

// >>> verification/tb_srd_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_srd_top import srd_pkg::*; ;
  localparam logic [1:0]  ME  = 2'h2;
  localparam logic [23:0] NOP = {1'b0, ME, 5'h00, 16'h0000};
  logic        clk = 1'b0, rst = 1'b1, sclk, sync_n, sdi, sdo, sdo_oe_n;
  logic        dev_addr_hi = 1'b1, dev_addr_lo = 1'b0, fault_pin = 1'b1, crc_en = 1'b0;
  logic        digital_diag_summary = 1'b0, analog_diag_summary = 1'b0, watchdog_flag = 1'b0, adc_busy = 1'b0;
  logic [4:0]  conv_channel_code = 5'h00, rb_ptr, wr_addr;
  logic [11:0] adc_result = 12'h000;
  logic [15:0] rb_data = 16'h0000, wr_data;
  logic [1:0]  rb_mode;
  logic        wr_strobe, invalid_access;
  logic [4:0]  rsv [3] = '{5'h19, 5'h1B, 5'h1D};
  logic [20:0] sv [2] = '{21'h0A5ABC, 21'h15A543};
  int          fail_count = 0, cmp_count = 0, n_wr = 0, n_inv = 0, cyc = 0;

  always #12.5 clk = ~clk;

  srd_top i_srd_top (.clk, .rst, .sclk, .sync_n, .sdi, .sdo, .sdo_oe_n, .dev_addr_hi, .dev_addr_lo,
    .fault_pin, .crc_en, .digital_diag_summary, .analog_diag_summary, .watchdog_flag, .adc_busy,
    .conv_channel_code, .adc_result, .rb_data, .rb_ptr, .rb_mode, .wr_strobe, .wr_addr, .wr_data,
    .invalid_access);

  srd_host_model i_srd_host_model (.clk, .sdo, .sdo_oe_n, .sclk, .sync_n, .sdi);

  // ==========================================================
  // Checking and closing
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic end_sim();
    if (fail_count == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Counting pulses also catches a strobe that stays high too long.
  always @(posedge clk) begin
    if (wr_strobe === 1'b1) n_wr <= n_wr + 1;
    if (invalid_access === 1'b1) n_inv <= n_inv + 1;
    cyc <= cyc + 1;
    if (cyc == 12000) begin
      fail_count++;
      end_sim();
    end
  end

  // ==========================================================
  // Frame helpers
  function automatic logic [23:0] f(logic [1:0] a, logic [4:0] r, logic [15:0] d);
    return {~a[1], a, r, d};
  endfunction

  task automatic op(input int len, input logic [31:0] w, input int ew, input int ei);
    int w0;
    int i0;
    w0 = n_wr;
    i0 = n_inv;
    i_srd_host_model.xfer(len, w);
    chk(n_wr - w0, ew);
    chk(n_inv - i0, ei);
  endtask

  task automatic stat(input logic [20:0] v);
    {digital_diag_summary, analog_diag_summary, watchdog_flag, adc_busy, conv_channel_code, adc_result} <= v;
  endtask

  // ==========================================================
  // Test sequence
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    chk(rb_ptr, 5'h00);
    chk(sdo_oe_n, 1'b1);
    op(24, f(ME, 5'h13, 16'h0005), 1, 0);
    chk(wr_addr, 5'h13);
    chk(wr_data, 16'h0005);
    chk(rb_ptr, 5'h05);
    rb_data <= 16'hA5C3;
    op(24, f(ME, 5'h13, 16'h0007), 1, 0);
    chk(i_srd_host_model.rx, 32'h00A5A5C3);
    rb_data <= 16'h3C5A;
    op(24, NOP, 1, 0);
    chk(i_srd_host_model.rx, 32'h00A73C5A);
    chk(wr_addr, 5'h00);
    for (int k = 0; k < 4; k++) begin
      {dev_addr_hi, dev_addr_lo} <= k[1:0];
      op(24, f(ME, 5'h13, 16'h0006), int'(k == 2), 0);
    end
    {dev_addr_hi, dev_addr_lo} <= ME;
    chk(rb_ptr, 5'h06);
    op(24, {1'b1, ME, 5'h13, 16'h0100}, 0, 0);
    chk(rb_mode, SRD_TWO_STAGE);
    for (int k = 0; k < 3; k++) begin
      op(24, f(ME, rsv[k], 16'h0000), 0, 1);
    end
    crc_en <= 1'b1;
    op(24, f(ME, 5'h13, 16'h0005), 0, 0);
    op(32, {f(ME, 5'h13, 16'h0005), 8'h5A}, 1, 0);
    chk(i_srd_host_model.rx, 32'hA63C5A00);
    crc_en <= 1'b0;
    op(32, {f(ME, 5'h13, 16'h0007), 8'hC3}, 1, 0);
    chk(rb_ptr, 5'h07);
    op(24, f(ME, 5'h13, 16'h0013), 1, 0);
    chk(i_srd_host_model.rx, 32'h00A73C5A);
    op(24, f(ME, 5'h13, 16'h0000), 1, 0);
    chk(i_srd_host_model.rx, 32'h00B30013);
    op(24, NOP, 1, 0);
    chk(i_srd_host_model.rx, 32'h00A00000);
    op(24, f(ME, 5'h13, 16'h0100), 1, 0);
    chk(rb_mode, SRD_AUTOSTATUS);
    for (int k = 0; k < 2; k++) begin
      fault_pin <= k[0];
      stat(sv[k]);
      op(24, NOP, 1, 0);
      chk(i_srd_host_model.rx, {8'h00, 2'h2, k[0], sv[k]});
    end
    op(24, f(ME, 5'h13, 16'h0200), 1, 0);
    chk(rb_mode, SRD_SHARED);
    op(24, NOP, 1, 0);
    chk(i_srd_host_model.drv, 1'b1);
    chk(i_srd_host_model.rx, {8'h00, 2'h2, 1'b1, sv[1]});
    op(24, f(2'h1, 5'h00, 16'h0000), 0, 0);
    op(24, NOP, 1, 0);
    chk(i_srd_host_model.drv, 1'b0);
    op(24, f(ME, 5'h13, 16'h0300), 1, 0);
    chk(rb_mode, SRD_ECHO);
    op(24, f(ME, 5'h01, 16'h1234), 1, 0);
    chk(i_srd_host_model.rx, {8'h00, 2'h2, 1'b1, sv[1]});
    op(24, NOP, 1, 0);
    chk(i_srd_host_model.rx, {8'h00, f(ME, 5'h01, 16'h1234)});
    end_sim();
  end
endmodule // tb_srd_top

`default_nettype wire
